// File: rtl/ccd_timing_pkg.sv
// How it works
// - Each effective reference period is split into 64 edge positions, 0 to 63.
// - Halving control at index 0x0D divides the reference rate by two.
// - Crystal drive output is the inverse of the reference clock input, delayed by three register stages.
// - Reset-gate clock has programmable rising and falling edges and polarity.
// - First horizontal clock has programmable rising and falling edges and polarity.
// - Mode 1: clocks three, five, seven follow one; even clocks are its inverse.
// - Every edge-location field is 6 bits and selects one of 64 positions.
// - 3-bit drive codes at 0x35/0x36: 0 off, 1-3 steps, 4-7 maximum.
// - Polarity bit inverts the waveform when 0 and passes it when 1.
// - Reset-level and signal-level strobes sit at 6-bit sampling positions.
// - Horizontal configuration field at 0x23 bits 9:7 selects output derivation.
// - Pixel and line counters run 0 to 8191 and place the line and field sync outputs.
// - Master mode: external sync resets counters and resynchronises line/field syncs.
// - Slave mode: field and line syncs come in and the pixel and line counters follow them.
// - Edge generation behaves the same in master and slave mode.
// - Host programs all timing parameters through the register port.
// - Configuration codes 001, 010, 100 are modes 1-3; all others invalid.
package ccd_timing_pkg;

  // ==========================================================================
  // Sizes.
  localparam int EDGE_BITS = 6;
  localparam int EDGE_POSITIONS = 64;
  localparam int PIX_BITS = 13;
  localparam int NUM_EDGE = 5;
  localparam int NUM_PINS = 10;
  localparam int DRV_BITS = 3;
  localparam int NUM_SYNC = 4;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_CLKDIV = 10'h00d;
  localparam logic [9:0] IDX_HCFG = 10'h023;
  localparam logic [9:0] IDX_DRV0 = 10'h035;
  localparam logic [9:0] IDX_DRV1 = 10'h036;
  localparam logic [9:0] IDX_EDGE_BASE = 10'h040;
  localparam logic [9:0] IDX_SAMP = 10'h045;
  localparam logic [9:0] IDX_SYNC = 10'h046;
  localparam logic [9:0] IDX_LINES = 10'h047;
  localparam logic [9:0] IDX_STATUS = 10'h048;

  // ==========================================================================
  // Field positions.
  localparam int CLKDIV_BIT = 0;
  localparam int HCFG_LSB = 7;
  localparam int EDGE_CFG_W = 13;
  localparam int DRV0_PINS = 6;
  localparam int DRV0_W = 18;
  localparam int DRV1_W = 12;
  localparam int SAMP_SHD_LSB = 6;
  localparam int SYNC_SLAVE_BIT = 0;
  localparam int SYNC_PPL_LSB = 1;
  localparam int STAT_LINE_LSB = 16;
  localparam int STAT_INVALID_BIT = 31;

  // Edge slots and pin slots.
  localparam int E_RG = 0;
  localparam int E_H1 = 1;
  localparam int E_H2 = 2;
  localparam int E_HL = 3;
  localparam int E_H5 = 4;
  localparam int P_RG = 0;
  localparam int P_HL = 1;
  localparam int P_H1 = 2;

  // Synchroniser slots.
  localparam int S_REF = 0;
  localparam int S_EXT = 1;
  localparam int S_FIELD = 2;
  localparam int S_LINE = 3;

  // ==========================================================================
  // Codes and reset values.
  localparam logic [2:0] HMODE1 = 3'h1;
  localparam logic [2:0] HMODE2 = 3'h2;
  localparam logic [2:0] HMODE3 = 3'h4;
  localparam logic [2:0] DRV_MAX = 3'h4;
  localparam logic [2:0] DRV_OFF = 3'h0;
  localparam logic [2:0] HCFG_RST = 3'h1;
  localparam logic [29:0] DRV_RST = 30'h12492492;
  localparam logic [11:0] SAMP_RST = 12'h820;
  localparam logic [12:0] PPL_RST = 13'h1fff;
  localparam logic [12:0] LPF_RST = 13'h1fff;
  localparam logic [5:0] PHASE_LAST = 6'h3f;

  typedef struct packed {
    logic pol;
    logic [5:0] fall;
    logic [5:0] rise;
  } edge_cfg_s;

  localparam edge_cfg_s EDGE_RST = '{pol: 1'b1, fall: 6'h20, rise: 6'h00};

  typedef struct packed {
    logic level;
    logic oe;
    logic [2:0] step;
  } pin_drive_s;

  typedef enum logic {SC_WAIT = 1'b0, SC_RUN = 1'b1} sync_state_e;

endpackage : ccd_timing_pkg

// File: rtl/edge_waveform_gen.sv
`timescale 1ns/100ps
module edge_waveform_gen (
  input wire logic [5:0] phase,
  input wire ccd_timing_pkg::edge_cfg_s cfg,
  output logic level
);

  logic raw;

  // ==========================================================================
  // Waveform from edge positions.
  always_comb begin
    if (cfg.rise < cfg.fall) begin
      raw = (phase >= cfg.rise) && (phase < cfg.fall);
    end else if (cfg.rise > cfg.fall) begin
      raw = (phase >= cfg.rise) || (phase < cfg.fall);
    end else begin
      raw = 1'b0;
    end
    level = cfg.pol ? raw : ~raw;
  end

endmodule : edge_waveform_gen

// File: rtl/sync_counter.sv
`timescale 1ns/100ps
module sync_counter (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic slaveMode,
  input wire logic extSync,
  input wire logic lineIn,
  input wire logic fieldIn,
  input wire logic [12:0] pplLast,
  input wire logic [12:0] lpfLast,
  output logic [12:0] pixel,
  output logic [12:0] line
);

  ccd_timing_pkg::sync_state_e state_reg, state_next;
  logic [12:0] pix_reg, pix_next, line_reg, line_next;

  // ==========================================================================
  // Pixel and line counters.
  always_comb begin
    state_next = state_reg;
    pix_next = pix_reg;
    line_next = line_reg;
    case (state_reg)
      ccd_timing_pkg::SC_WAIT: begin
        if (!slaveMode || fieldIn) begin
          state_next = ccd_timing_pkg::SC_RUN;
          pix_next = '0;
          line_next = '0;
        end
      end
      ccd_timing_pkg::SC_RUN: begin
        if (slaveMode) begin
          if (fieldIn) begin
            pix_next = '0;
            line_next = '0;
          end else if (lineIn) begin
            pix_next = '0;
            line_next = (line_reg == lpfLast) ? '0 : 13'(line_reg + 13'h1);
          end else if (tick && pix_reg != pplLast) begin
            pix_next = 13'(pix_reg + 13'h1);
          end
        end else if (extSync) begin
          pix_next = '0;
          line_next = '0;
        end else if (tick) begin
          if (pix_reg == pplLast) begin
            pix_next = '0;
            line_next = (line_reg == lpfLast) ? '0 : 13'(line_reg + 13'h1);
          end else begin
            pix_next = 13'(pix_reg + 13'h1);
          end
        end
      end
      default: state_next = ccd_timing_pkg::SC_WAIT;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ccd_timing_pkg::SC_WAIT;
      pix_reg <= '0;
      line_reg <= '0;
    end else begin
      state_reg <= state_next;
      pix_reg <= pix_next;
      line_reg <= line_next;
    end
  end

  assign pixel = pix_reg;
  assign line = line_reg;

endmodule : sync_counter

// File: rtl/ccd_high_speed_edge_timing_core.sv
`timescale 1ns/100ps
module ccd_high_speed_edge_timing_core (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reference_clock_in,
  output logic crystal_drive_out,
  input wire logic external_sync,
  input wire logic field_sync_in,
  output logic field_sync_out,
  output logic field_sync_oe,
  input wire logic line_sync_in,
  output logic line_sync_out,
  output logic line_sync_oe,
  output ccd_timing_pkg::pin_drive_s reset_gate_clock,
  output ccd_timing_pkg::pin_drive_s last_horizontal_clock,
  output ccd_timing_pkg::pin_drive_s horizontal_clock_one,
  output ccd_timing_pkg::pin_drive_s horizontal_clock_two,
  output ccd_timing_pkg::pin_drive_s horizontal_clock_three,
  output ccd_timing_pkg::pin_drive_s horizontal_clock_four,
  output ccd_timing_pkg::pin_drive_s horizontal_clock_five,
  output ccd_timing_pkg::pin_drive_s horizontal_clock_six,
  output ccd_timing_pkg::pin_drive_s horizontal_clock_seven,
  output ccd_timing_pkg::pin_drive_s horizontal_clock_eight,
  output logic reset_level_sample,
  output logic signal_level_sample
);

  // ==========================================================================
  // Declarations.
  logic [9:0] idx;
  logic setupPhase, accessPhase, hit;
  logic [31:0] rdata;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic ref_clock_halve_reg, ref_clock_halve_next;
  logic [2:0] horizontal_output_config_reg, horizontal_output_config_next;
  ccd_timing_pkg::edge_cfg_s edgeCfg_reg [ccd_timing_pkg::NUM_EDGE];
  ccd_timing_pkg::edge_cfg_s edgeCfg_next [ccd_timing_pkg::NUM_EDGE];
  logic [29:0] drv_reg, drv_next;
  logic [11:0] samp_reg, samp_next;
  logic slave_reg, slave_next;
  logic [12:0] ppl_reg, ppl_next, lpf_reg, lpf_next;
  logic [5:0] phase_reg, phase_next;
  logic halfTick_reg, halfTick_next;
  logic advance, periodEnd;
  logic [ccd_timing_pkg::NUM_SYNC-1:0] syncA_reg, syncB_reg, syncC_reg;
  logic [12:0] pixel, line;
  logic [ccd_timing_pkg::NUM_EDGE-1:0] edgeLevel;
  logic [7:0] hLevel;
  logic configInvalid;
  logic [ccd_timing_pkg::NUM_PINS-1:0] pinLevel;
  ccd_timing_pkg::pin_drive_s pin_reg [ccd_timing_pkg::NUM_PINS];
  ccd_timing_pkg::pin_drive_s pin_next [ccd_timing_pkg::NUM_PINS];
  logic resetSample_reg, resetSample_next, signalSample_reg, signalSample_next;
  logic crystal_reg, crystal_next, syncOe_reg, syncOe_next;
  logic fieldOut_reg, fieldOut_next, lineOut_reg, lineOut_next;

  // ==========================================================================
  // Register port.
  assign idx = paddr[11:2];
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable && pready_reg;

  always_comb begin
    hit = 1'b1;
    rdata = '0;
    case (idx)
      ccd_timing_pkg::IDX_CLKDIV: rdata[ccd_timing_pkg::CLKDIV_BIT] = ref_clock_halve_reg;
      ccd_timing_pkg::IDX_HCFG: rdata[ccd_timing_pkg::HCFG_LSB+:3] = horizontal_output_config_reg;
      ccd_timing_pkg::IDX_DRV0: rdata[ccd_timing_pkg::DRV0_W-1:0] = drv_reg[ccd_timing_pkg::DRV0_W-1:0];
      ccd_timing_pkg::IDX_DRV1: rdata[ccd_timing_pkg::DRV1_W-1:0] = drv_reg[29:ccd_timing_pkg::DRV0_W];
      ccd_timing_pkg::IDX_SAMP: rdata[11:0] = samp_reg;
      ccd_timing_pkg::IDX_SYNC: begin
        rdata[ccd_timing_pkg::SYNC_SLAVE_BIT] = slave_reg;
        rdata[ccd_timing_pkg::SYNC_PPL_LSB+:13] = ppl_reg;
      end
      ccd_timing_pkg::IDX_LINES: rdata[12:0] = lpf_reg;
      ccd_timing_pkg::IDX_STATUS: begin
        rdata[12:0] = pixel;
        rdata[ccd_timing_pkg::STAT_LINE_LSB+:13] = line;
        rdata[ccd_timing_pkg::STAT_INVALID_BIT] = configInvalid;
      end
      default: hit = 1'b0;
    endcase
    for (int i = 0; i < ccd_timing_pkg::NUM_EDGE; i++) begin
      if (idx == 10'(ccd_timing_pkg::IDX_EDGE_BASE + 10'(i))) begin
        hit = 1'b1;
        rdata[ccd_timing_pkg::EDGE_CFG_W-1:0] = edgeCfg_reg[i];
      end
    end
  end

  always_comb begin
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    pready_next = setupPhase;
    ref_clock_halve_next = ref_clock_halve_reg;
    horizontal_output_config_next = horizontal_output_config_reg;
    edgeCfg_next = edgeCfg_reg;
    drv_next = drv_reg;
    samp_next = samp_reg;
    slave_next = slave_reg;
    ppl_next = ppl_reg;
    lpf_next = lpf_reg;
    if (setupPhase) begin
      prdata_next = pwrite ? '0 : rdata;
      pslverr_next = !hit;
    end
    if (accessPhase && pwrite) begin
      case (idx)
        ccd_timing_pkg::IDX_CLKDIV: ref_clock_halve_next = pwdata[ccd_timing_pkg::CLKDIV_BIT];
        ccd_timing_pkg::IDX_HCFG: horizontal_output_config_next = pwdata[ccd_timing_pkg::HCFG_LSB+:3];
        ccd_timing_pkg::IDX_DRV0: drv_next[ccd_timing_pkg::DRV0_W-1:0] = pwdata[ccd_timing_pkg::DRV0_W-1:0];
        ccd_timing_pkg::IDX_DRV1: drv_next[29:ccd_timing_pkg::DRV0_W] = pwdata[ccd_timing_pkg::DRV1_W-1:0];
        ccd_timing_pkg::IDX_SAMP: samp_next = pwdata[11:0];
        ccd_timing_pkg::IDX_SYNC: begin
          slave_next = pwdata[ccd_timing_pkg::SYNC_SLAVE_BIT];
          ppl_next = pwdata[ccd_timing_pkg::SYNC_PPL_LSB+:13];
        end
        ccd_timing_pkg::IDX_LINES: lpf_next = pwdata[12:0];
        default: begin
        end
      endcase
      for (int i = 0; i < ccd_timing_pkg::NUM_EDGE; i++) begin
        if (idx == 10'(ccd_timing_pkg::IDX_EDGE_BASE + 10'(i))) begin
          edgeCfg_next[i] = ccd_timing_pkg::edge_cfg_s'(pwdata[ccd_timing_pkg::EDGE_CFG_W-1:0]);
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      ref_clock_halve_reg <= 1'b0;
      horizontal_output_config_reg <= ccd_timing_pkg::HCFG_RST;
      for (int i = 0; i < ccd_timing_pkg::NUM_EDGE; i++) begin
        edgeCfg_reg[i] <= ccd_timing_pkg::EDGE_RST;
      end
      drv_reg <= ccd_timing_pkg::DRV_RST;
      samp_reg <= ccd_timing_pkg::SAMP_RST;
      slave_reg <= 1'b0;
      ppl_reg <= ccd_timing_pkg::PPL_RST;
      lpf_reg <= ccd_timing_pkg::LPF_RST;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      ref_clock_halve_reg <= ref_clock_halve_next;
      horizontal_output_config_reg <= horizontal_output_config_next;
      edgeCfg_reg <= edgeCfg_next;
      drv_reg <= drv_next;
      samp_reg <= samp_next;
      slave_reg <= slave_next;
      ppl_reg <= ppl_next;
      lpf_reg <= lpf_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ==========================================================================
  // Edge position counter.
  always_comb begin
    halfTick_next = ref_clock_halve_reg ? ~halfTick_reg : 1'b0;
    advance = !ref_clock_halve_reg || halfTick_reg;
    phase_next = advance ? 6'(phase_reg + 6'h1) : phase_reg;
    periodEnd = advance && (phase_reg == ccd_timing_pkg::PHASE_LAST);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= '0;
      halfTick_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      halfTick_reg <= halfTick_next;
    end
  end

  // ==========================================================================
  // Pin synchronisers.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      syncC_reg <= '0;
    end else begin
      syncA_reg <= {line_sync_in, field_sync_in, external_sync, reference_clock_in};
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
    end
  end

  // ==========================================================================
  // Pixel and line counting.
  sync_counter u_counter (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(periodEnd),
    .slaveMode(slave_reg),
    .extSync(syncB_reg[ccd_timing_pkg::S_EXT] && !syncC_reg[ccd_timing_pkg::S_EXT]),
    .lineIn(syncB_reg[ccd_timing_pkg::S_LINE] && !syncC_reg[ccd_timing_pkg::S_LINE]),
    .fieldIn(syncB_reg[ccd_timing_pkg::S_FIELD] && !syncC_reg[ccd_timing_pkg::S_FIELD]),
    .pplLast(ppl_reg),
    .lpfLast(lpf_reg),
    .pixel(pixel),
    .line(line)
  );

  // ==========================================================================
  // Edge waveforms.
  // independent of sync mode
  for (genvar g = 0; g < ccd_timing_pkg::NUM_EDGE; g++) begin : g_edge
    edge_waveform_gen u_gen (
      .phase(phase_reg),
      .cfg(edgeCfg_reg[g]),
      .level(edgeLevel[g])
    );
  end

  // ==========================================================================
  // Horizontal mapping and output drivers.
  always_comb begin
    configInvalid = 1'b0;
    hLevel = '0;
    case (horizontal_output_config_reg)
      ccd_timing_pkg::HMODE1: hLevel = {4{~edgeLevel[ccd_timing_pkg::E_H1], edgeLevel[ccd_timing_pkg::E_H1]}};
      ccd_timing_pkg::HMODE2: hLevel = {4{edgeLevel[ccd_timing_pkg::E_H2], edgeLevel[ccd_timing_pkg::E_H1]}};
      ccd_timing_pkg::HMODE3: hLevel = {{2{~edgeLevel[ccd_timing_pkg::E_H5], edgeLevel[ccd_timing_pkg::E_H5]}},
                                        {2{~edgeLevel[ccd_timing_pkg::E_H1], edgeLevel[ccd_timing_pkg::E_H1]}}};
      default: configInvalid = 1'b1;
    endcase
    pinLevel = {hLevel, edgeLevel[ccd_timing_pkg::E_HL], edgeLevel[ccd_timing_pkg::E_RG]};
  end

  for (genvar p = 0; p < ccd_timing_pkg::NUM_PINS; p++) begin : g_pin
    logic [2:0] code;
    assign code = drv_reg[p*ccd_timing_pkg::DRV_BITS+:ccd_timing_pkg::DRV_BITS];
    always_comb begin
      pin_next[p].level = pinLevel[p];
      pin_next[p].oe = (code != ccd_timing_pkg::DRV_OFF);
      pin_next[p].step = (code > ccd_timing_pkg::DRV_MAX) ? ccd_timing_pkg::DRV_MAX : code;
    end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        pin_reg[p] <= '0;
      end else begin
        pin_reg[p] <= pin_next[p];
      end
    end
  end

  // ==========================================================================
  // Strobes, crystal drive and sync outputs.
  always_comb begin
    resetSample_next = (phase_reg == samp_reg[5:0]);
    signalSample_next = (phase_reg == samp_reg[ccd_timing_pkg::SAMP_SHD_LSB+:6]);
    crystal_next = ~syncB_reg[ccd_timing_pkg::S_REF];
    lineOut_next = !slave_reg && (pixel == '0);
    fieldOut_next = !slave_reg && (line == '0);
    syncOe_next = !slave_next;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resetSample_reg <= 1'b0;
      signalSample_reg <= 1'b0;
      crystal_reg <= 1'b1;
      lineOut_reg <= 1'b0;
      fieldOut_reg <= 1'b0;
      syncOe_reg <= 1'b1;
    end else begin
      resetSample_reg <= resetSample_next;
      signalSample_reg <= signalSample_next;
      crystal_reg <= crystal_next;
      lineOut_reg <= lineOut_next;
      fieldOut_reg <= fieldOut_next;
      syncOe_reg <= syncOe_next;
    end
  end

  assign reset_level_sample = resetSample_reg;
  assign signal_level_sample = signalSample_reg;
  assign crystal_drive_out = crystal_reg;
  assign line_sync_out = lineOut_reg;
  assign field_sync_out = fieldOut_reg;
  assign line_sync_oe = syncOe_reg;
  assign field_sync_oe = syncOe_reg;
  assign reset_gate_clock = pin_reg[ccd_timing_pkg::P_RG];
  assign last_horizontal_clock = pin_reg[ccd_timing_pkg::P_HL];
  assign horizontal_clock_one = pin_reg[ccd_timing_pkg::P_H1];
  assign horizontal_clock_two = pin_reg[ccd_timing_pkg::P_H1+1];
  assign horizontal_clock_three = pin_reg[ccd_timing_pkg::P_H1+2];
  assign horizontal_clock_four = pin_reg[ccd_timing_pkg::P_H1+3];
  assign horizontal_clock_five = pin_reg[ccd_timing_pkg::P_H1+4];
  assign horizontal_clock_six = pin_reg[ccd_timing_pkg::P_H1+5];
  assign horizontal_clock_seven = pin_reg[ccd_timing_pkg::P_H1+6];
  assign horizontal_clock_eight = pin_reg[ccd_timing_pkg::P_H1+7];

endmodule : ccd_high_speed_edge_timing_core

// File: tb/ccd_high_speed_edge_timing_core_assertions.sv
`timescale 1ns/100ps
// ========================================
// Port relations of the timing core.
module ccd_high_speed_edge_timing_core_assertions (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reference_clock_in,
  input wire logic crystal_drive_out,
  input wire logic field_sync_oe,
  input wire logic line_sync_oe,
  input wire logic reset_level_sample,
  input wire ccd_timing_pkg::pin_drive_s reset_gate_clock,
  input wire ccd_timing_pkg::pin_drive_s horizontal_clock_one,
  input wire ccd_timing_pkg::pin_drive_s horizontal_clock_two,
  input wire ccd_timing_pkg::pin_drive_s horizontal_clock_three,
  input wire ccd_timing_pkg::pin_drive_s horizontal_clock_four
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  function automatic logic mapped(input logic [9:0] idx);
    return idx inside {10'h00d, 10'h023, 10'h035, 10'h036} || (idx >= 10'h040 && idx <= 10'h048);
  endfunction : mapped
  a_answer_next: assert property (psel && !penable |=> pready)
    else $error("No answer after setup.");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("Ready held too long.");
  a_error_map: assert property (psel && penable && pready |-> pslverr == !mapped(paddr[11:2]))
    else $error("Error flag wrong.");
  a_clo_low: assert property (reference_clock_in [*4] |-> !crystal_drive_out)
    else $error("Crystal drive not low.");
  a_clo_high: assert property (!reference_clock_in [*4] |-> crystal_drive_out)
    else $error("Crystal drive not high.");
  a_odd_follow: assert property (horizontal_clock_three.level == horizontal_clock_one.level)
    else $error("Clock three differs from one.");
  a_even_follow: assert property (horizontal_clock_four.level == horizontal_clock_two.level)
    else $error("Clock four differs from two.");
  a_drive_code: assert property (reset_gate_clock.oe == (reset_gate_clock.step != 3'h0))
    else $error("Drive enable wrong.");
  a_drive_max: assert property (reset_gate_clock.step <= 3'h4)
    else $error("Drive step too large.");
  a_sync_pair: assert property (field_sync_oe == line_sync_oe)
    else $error("Sync enables differ.");
  a_strobe_short: assert property ($rose(reset_level_sample) |-> ##2 !reset_level_sample)
    else $error("Strobe too long.");
  c_error: cover property (pslverr);
  c_slave: cover property ($fell(field_sync_oe));
  c_strobe: cover property ($rose(reset_level_sample));
endmodule : ccd_high_speed_edge_timing_core_assertions
bind ccd_high_speed_edge_timing_core ccd_high_speed_edge_timing_core_assertions i_assertions (.*);

// File: tb/ccd_sensor_model.sv
`timescale 1ns/100ps
// ========================================
// Reset gate input of the sensor.
module ccd_sensor_model (
  input wire logic ref_clk,
  input wire ccd_timing_pkg::pin_drive_s gateIn,
  output logic sensedGate = 1'b0
);
  always @(posedge ref_clk) sensedGate <= gateIn.oe ? gateIn.level : ~sensedGate;
endmodule : ccd_sensor_model

// File: tb/ccd_high_speed_edge_timing_core_test.sv
`timescale 1ns/100ps
// ========================================
// Self-checking bench for the timing core.
module ccd_high_speed_edge_timing_core_test;
  logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, external_sync = 1'b0;
  logic fieldDrv = 1'b0, lineDrv = 1'b0, err, pready, pslverr, crystal_drive_out, reset_level_sample;
  logic signal_level_sample, field_sync_out, field_sync_oe, line_sync_out, line_sync_oe, sensedGate;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] refCnt = 3'h0;
  ccd_timing_pkg::pin_drive_s reset_gate_clock, last_horizontal_clock, horizontal_clock_one, horizontal_clock_two;
  ccd_timing_pkg::pin_drive_s horizontal_clock_three, horizontal_clock_four, horizontal_clock_five;
  ccd_timing_pkg::pin_drive_s horizontal_clock_six, horizontal_clock_seven, horizontal_clock_eight;
  int badCount = 0, nCompared = 0;
  wire logic reference_clock_in = refCnt[2];
  wire logic field_sync_in = field_sync_oe ? field_sync_out : fieldDrv;
  wire logic line_sync_in = line_sync_oe ? line_sync_out : lineDrv;

  ccd_high_speed_edge_timing_core i_ccd_high_speed_edge_timing_core (.*);
  ccd_sensor_model i_ccd_sensor_model (.ref_clk(ref_clk), .gateIn(reset_gate_clock), .sensedGate(sensedGate));

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) refCnt <= refCnt + 3'h1;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      badCount++;
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cnt(input int len, output int c1, output int c2, output int c5, output int cg);
    c1 = 0;
    c2 = 0;
    c5 = 0;
    cg = 0;
    repeat (3) @(posedge ref_clk);
    repeat (len) begin
      @(negedge ref_clk);
      c1 += horizontal_clock_one.level;
      c2 += horizontal_clock_two.level;
      c5 += horizontal_clock_five.level;
      cg += sensedGate;
    end
  endtask : cnt

  task automatic t_regs();
    logic [9:0] idx [5] = '{10'h023, 10'h035, 10'h036, 10'h041, 10'h045};
    logic [31:0] exp [5] = '{32'h80, 32'h12492, 32'h492, 32'h1800, 32'h820};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, idx[i], 32'h0);
      chk("reset value", exp[i], rd);
      chk("mapped error", 0, err);
    end
    apb(1'b0, 10'h3ff, 32'h0);
    chk("unmapped error", 1, err);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 10'h035, {14'h0, 15'h2492, 3'(c)});
      repeat (3) @(posedge ref_clk);
      chk("drive step", (c > 4) ? 4 : c, reset_gate_clock.step);
      chk("drive enable", c != 0, reset_gate_clock.oe);
    end
  endtask : t_regs

  task automatic t_edges();
    int c1, c2, c5, cg;
    logic [2:0] mode [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
    int e2 [4] = '{62, 0, 62, 0};
    int e5 [4] = '{2, 2, 32, 0};
    apb(1'b1, 10'h041, 32'h1102);
    apb(1'b1, 10'h042, 32'h1000);
    apb(1'b1, 10'h040, 32'h150a);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 10'h023, {22'h0, mode[i], 7'h0});
      cnt(64, c1, c2, c5, cg);
      chk("h2 high", e2[i], c2);
      chk("h5 high", e5[i], c5);
      chk("h7 follows h5", horizontal_clock_five.level, horizontal_clock_seven.level);
      chk("h8 follows h6", horizontal_clock_six.level, horizontal_clock_eight.level);
    end
    apb(1'b0, 10'h048, 32'h0);
    chk("bad mode flag", 1, rd[31]);
    apb(1'b1, 10'h023, 32'h80);
    cnt(64, c1, c2, c5, cg);
    chk("h1 high", 2, c1);
    chk("gate high", 10, cg);
    apb(1'b1, 10'h041, 32'h0102);
    apb(1'b1, 10'h00d, 32'h1);
    cnt(128, c1, c2, c5, cg);
    chk("h1 inverted halved", 124, c1);
    chk("h2 halved", 4, c2);
    apb(1'b1, 10'h00d, 32'h0);
  endtask : t_edges

  task automatic t_sample();
    int tr, ts;
    apb(1'b1, 10'h045, 32'h50a);
    repeat (3) @(posedge ref_clk);
    tr = -1;
    ts = -1;
    for (int i = 0; i < 64; i++) begin
      @(negedge ref_clk);
      if (reset_level_sample === 1'b1) tr = i;
      if (signal_level_sample === 1'b1) ts = i;
    end
    chk("strobe spacing", 10, (ts - tr + 64) % 64);
  endtask : t_sample

  task automatic t_sync();
    int c1, c2, c5, cg;
    apb(1'b1, 10'h046, 32'h2);
    for (int k = 0; k < 2; k++) begin
      external_sync <= 1'b1;
      repeat (4) @(posedge ref_clk);
      external_sync <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk("field sync restart", 1, field_sync_out);
      repeat (300) @(posedge ref_clk);
      chk("field sync later", 0, field_sync_out);
    end
    apb(1'b1, 10'h046, 32'h3);
    fieldDrv <= 1'b1;
    repeat (4) @(posedge ref_clk);
    lineDrv <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("sync drive off", 0, field_sync_oe);
    apb(1'b0, 10'h048, 32'h0);
    chk("slave line", 1, rd[28:16]);
    cnt(64, c1, c2, c5, cg);
    chk("h1 in slave", 62, c1);
  endtask : t_sync

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    #200000;
    badCount++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_edges();
    t_sample();
    t_sync();
    conclude();
  end
endmodule : ccd_high_speed_edge_timing_core_test
